// file: hw/swtrig_regs.vh
// register offsets, field positions, reset values and timing counts for the software trigger block
`ifndef SWTRIG_REGS_VH
`define SWTRIG_REGS_VH
`define SLOTS_0_TO_3_OFS 8'h00
`define SLOTS_4_TO_7_OFS 8'h04
`define SLOTS_8_TO_11_OFS 8'h08
`define CONTROL_OFS 8'h0c
`define RUN_STATUS_OFS 8'h10
`define IRQ_STATUS_OFS 8'h14
`define IRQ_MASK_OFS 8'h18
`define SLOT_ENABLE_BIT 7
`define SLOT_SEL_MSB 4
`define SLOT_WRITE_MASK 32'h9f9f9f9f
`define SLOT_RESET 32'h00000000
`define CTRL_START_BIT 0
`define CTRL_UNIT_B_BIT 1
`define IRQ_DONE_BIT 0
`define IRQ_RESERVED_BIT 1
`define SEL_LAST_COMMON 5'h0e
`define SEL_LAST_UNIT_B 5'h10
`define CONV_TIME_NS 1000
`define CLK_PERIOD_NS 4
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: hw/slot_scanner.v
// finds the next enabled program slot at or above a start index
`timescale 1ns/1ns
`default_nettype none
module slot_scanner #(
    parameter SLOTS = 12,
    parameter IW = 4
) (
    input wire [SLOTS-1:0] i_enables,
    input wire [IW-1:0] i_from,
    output reg o_found,
    output reg [IW-1:0] o_index
);
    integer k;
    always @*
    begin
        o_found = 1'b0;
        o_index = {IW{1'b0}};
        for (k = SLOTS - 1; k >= 0; k = k - 1)
        begin
            if (i_enables[k] && (k >= i_from))
            begin
                o_found = 1'b1;
                o_index = k[IW-1:0];
            end
        end
    end
endmodule // slot_scanner
`default_nettype wire

// file: hw/conv_timer.v
// counts one conversion time and pulses when it ends
`timescale 1ns/1ns
`default_nettype none
`include "swtrig_regs.vh"
module conv_timer #(
    parameter CW = 12,
    parameter [CW-1:0] CYCLES = `CONV_CYCLES
) (
    input wire i_ref_clk,
    input wire i_rst_n,
    input wire i_start,
    output reg o_done
);
    reg [CW-1:0] count_q;
    reg busy_q;
    always @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            count_q <= {CW{1'b0}};
            busy_q <= 1'b0;
            o_done <= 1'b0;
        end
        else
        begin
            o_done <= 1'b0;
            if (i_start)
            begin
                count_q <= CYCLES - {{(CW-1){1'b0}}, 1'b1};
                busy_q <= 1'b1;
            end
            else if (busy_q)
            begin
                if (count_q == {CW{1'b0}})
                begin
                    busy_q <= 1'b0;
                    o_done <= 1'b1;
                end
                else
                begin
                    count_q <= count_q - {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // conv_timer
`default_nettype wire

// file: hw/sw_trigger_program.v
// software-triggered conversion program table with run sequencer and interrupt
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "swtrig_regs.vh"
module sw_trigger_program #(
    parameter SLOTS = 12,
    parameter IW = 4,
    parameter CW = 12,
    parameter [CW-1:0] CONV_CYCLES = `CONV_CYCLES
) (
    input wire i_ref_clk,
    input wire i_rst_n,
    input wire [7:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    output reg o_conv_start,
    output reg [4:0] o_channel_select,
    output reg [IW-1:0] o_result_index,
    output reg o_result_write,
    output reg o_busy,
    output reg o_sw_conversion_done_irq
);
    //----------------------------------------
    // state and storage
    //----------------------------------------
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_CONV = 3'b010;
    localparam [2:0] ST_NEXT = 3'b100;

    reg [31:0] slots_q [0:2];
    reg unit_b_q;
    reg [2:0] state_q;
    reg [IW-1:0] cur_q;
    reg done_sts_q;
    reg resv_sts_q;
    reg [1:0] mask_q;
    reg [IW-1:0] from_q;
    reg start_timer_q;
    wire [SLOTS-1:0] enables;
    wire found;
    wire [IW-1:0] next_idx;
    wire conv_done;
    wire start_req;
    wire done_evt;
    wire resv_evt;
    reg [4:0] cur_sel;
    integer w;

    function [4:0] slot_sel;
        input [IW-1:0] idx;
        input [95:0] tbl;
        begin
            slot_sel = tbl[idx*8 +: 5];
        end
    endfunction

    function sel_reserved;
        input [4:0] sel;
        input unit_b;
        begin
            if (unit_b)
                sel_reserved = (sel > `SEL_LAST_UNIT_B);
            else
                sel_reserved = (sel > `SEL_LAST_COMMON);
        end
    endfunction

    wire [95:0] table_flat = {slots_q[2], slots_q[1], slots_q[0]};

    genvar g;
    generate
        for (g = 0; g < SLOTS; g = g + 1)
        begin : g_en
            assign enables[g] = table_flat[g*8 + `SLOT_ENABLE_BIT];
        end
    endgenerate

    //----------------------------------------
    // helpers
    //----------------------------------------
    slot_scanner #(
        .SLOTS(SLOTS),
        .IW(IW)
    ) u_scan (
        .i_enables(enables),
        .i_from(from_q),
        .o_found(found),
        .o_index(next_idx)
    );

    conv_timer #(
        .CW(CW),
        .CYCLES(CONV_CYCLES)
    ) u_timer (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_start(start_timer_q),
        .o_done(conv_done)
    );

    assign start_req = i_wr && (i_addr == `CONTROL_OFS) && i_wdata[`CTRL_START_BIT];
    assign done_evt = (state_q == ST_NEXT) && !found;

    always @*
    begin
        cur_sel = slot_sel(next_idx, table_flat);
    end
    assign resv_evt = (state_q == ST_NEXT) && found && sel_reserved(cur_sel, unit_b_q);

    //----------------------------------------
    // register writes
    //----------------------------------------
    always @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (w = 0; w < 3; w = w + 1)
                slots_q[w] <= `SLOT_RESET;
            unit_b_q <= 1'b0;
            mask_q <= 2'b00;
        end
        else if (i_wr)
        begin
            case (i_addr)
                `SLOTS_0_TO_3_OFS: slots_q[0] <= i_wdata & `SLOT_WRITE_MASK;
                `SLOTS_4_TO_7_OFS: slots_q[1] <= i_wdata & `SLOT_WRITE_MASK;
                `SLOTS_8_TO_11_OFS: slots_q[2] <= i_wdata & `SLOT_WRITE_MASK;
                `CONTROL_OFS: unit_b_q <= i_wdata[`CTRL_UNIT_B_BIT];
                `IRQ_MASK_OFS: mask_q <= i_wdata[1:0];
                default: ;
            endcase
        end
    end

    //----------------------------------------
    // sticky interrupt status, set beats clear
    //----------------------------------------
    always @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            done_sts_q <= 1'b0;
            resv_sts_q <= 1'b0;
            o_sw_conversion_done_irq <= 1'b0;
        end
        else
        begin
            if (done_evt)
                done_sts_q <= 1'b1;
            else if (i_wr && i_addr == `IRQ_STATUS_OFS && i_wdata[`IRQ_DONE_BIT])
                done_sts_q <= 1'b0;
            if (resv_evt)
                resv_sts_q <= 1'b1;
            else if (i_wr && i_addr == `IRQ_STATUS_OFS && i_wdata[`IRQ_RESERVED_BIT])
                resv_sts_q <= 1'b0;
            o_sw_conversion_done_irq <= |({resv_sts_q, done_sts_q} & mask_q);
        end
    end

    //----------------------------------------
    // run sequencer
    //----------------------------------------
    always @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_q <= ST_IDLE;
            cur_q <= {IW{1'b0}};
            from_q <= {IW{1'b0}};
            start_timer_q <= 1'b0;
            o_conv_start <= 1'b0;
            o_channel_select <= 5'h00;
            o_result_index <= {IW{1'b0}};
            o_result_write <= 1'b0;
            o_busy <= 1'b0;
        end
        else
        begin
            start_timer_q <= 1'b0;
            o_conv_start <= 1'b0;
            o_result_write <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (start_req)
                    begin
                        from_q <= {IW{1'b0}};
                        state_q <= ST_NEXT;
                        o_busy <= 1'b1;
                    end
                end
                ST_NEXT:
                begin
                    if (found)
                    begin
                        cur_q <= next_idx;
                        o_channel_select <= cur_sel;
                        start_timer_q <= 1'b1;
                        o_conv_start <= 1'b1;
                        state_q <= ST_CONV;
                    end
                    else
                    begin
                        state_q <= ST_IDLE;
                        o_busy <= 1'b0;
                    end
                end
                ST_CONV:
                begin
                    if (conv_done)
                    begin
                        o_result_index <= cur_q;
                        o_result_write <= 1'b1;
                        from_q <= cur_q + {{(IW-1){1'b0}}, 1'b1};
                        state_q <= ST_NEXT;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    //----------------------------------------
    // register reads, data in the next cycle
    //----------------------------------------
    always @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_rdata <= 32'h00000000;
        else if (i_rd)
        begin
            case (i_addr)
                `SLOTS_0_TO_3_OFS: o_rdata <= slots_q[0];
                `SLOTS_4_TO_7_OFS: o_rdata <= slots_q[1];
                `SLOTS_8_TO_11_OFS: o_rdata <= slots_q[2];
                `CONTROL_OFS: o_rdata <= {30'h00000000, unit_b_q, 1'b0};
                `RUN_STATUS_OFS: o_rdata <= {{(27-IW){1'b0}}, cur_q, 4'h0, o_busy};
                `IRQ_STATUS_OFS: o_rdata <= {30'h00000000, resv_sts_q, done_sts_q};
                `IRQ_MASK_OFS: o_rdata <= {30'h00000000, mask_q};
                default: o_rdata <= 32'h00000000;
            endcase
        end
        else
            o_rdata <= 32'h00000000;
    end
endmodule // sw_trigger_program
`default_nettype wire

// file: test/swtrig_chk.sv
// assertions on the ports of the software trigger program block
`timescale 1ns/1ns
`default_nettype none
module swtrig_chk #(
    parameter CONV_CYCLES = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic o_conv_start,
    input wire logic [4:0] o_channel_select,
    input wire logic [3:0] o_result_index,
    input wire logic o_result_write,
    input wire logic o_busy,
    input wire logic o_sw_conversion_done_irq
);
    // start pulse, timer load, count down, done pulse, then the result strobe
    localparam int PAIR = CONV_CYCLES + 2;
    logic mask_q;
    logic seen_q;
    logic [3:0] prev_q;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // track the done mask and the last result slot of the run
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            mask_q <= 1'b0;
            seen_q <= 1'b0;
            prev_q <= 4'h0;
        end
        else
        begin
            if (i_wr && i_addr == 8'h18)
                mask_q <= i_wdata[0];
            if (!o_busy)
                seen_q <= 1'b0;
            else if (o_result_write)
            begin
                seen_q <= 1'b1;
                prev_q <= o_result_index;
            end
        end
    end
    a_rd_idle: assert property (!i_rd |=> o_rdata == 32'h0)
        else $error("read data not zero");
    a_pad_zero: assert property (i_rd && i_addr < 8'h0c |=> (o_rdata & 32'h60606060) == 0)
        else $error("pad bits not zero");
    a_start_busy: assert property (i_wr && i_addr == 8'h0c && i_wdata[0] && !o_busy |=> o_busy)
        else $error("start ignored");
    a_result_pair: assert property (o_conv_start |-> ##PAIR o_result_write)
        else $error("result write late");
    a_start_pulse: assert property (o_conv_start |=> !o_conv_start)
        else $error("start too long");
    a_order_up: assert property (o_result_write && seen_q |-> o_result_index > prev_q)
        else $error("slot order");
    a_idle_quiet: assert property (!o_busy |-> !o_conv_start && !o_result_write)
        else $error("activity while idle");
    a_done_irq: assert property ($fell(o_busy) && mask_q |=> o_sw_conversion_done_irq)
        else $error("done irq missing");
    c_result: cover property (o_result_write);
    c_irq: cover property ($fell(o_busy) && mask_q);
    c_unmapped: cover property (i_rd && i_addr == 8'h40);
endmodule // swtrig_chk
bind sw_trigger_program swtrig_chk #(.CONV_CYCLES(CONV_CYCLES)) swtrig_chk_i (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_conv_start(o_conv_start),
    .o_channel_select(o_channel_select), .o_result_index(o_result_index),
    .o_result_write(o_result_write), .o_busy(o_busy),
    .o_sw_conversion_done_irq(o_sw_conversion_done_irq));
`default_nettype wire

// file: test/analog_inputs_model.sv
// far-side analog inputs: log each converted channel and each result slot
`timescale 1ns/1ns
`default_nettype none
module analog_inputs_model (
    input wire logic i_ref_clk,
    input wire logic i_conv_start,
    input wire logic [4:0] i_channel_select,
    input wire logic i_result_write,
    input wire logic [3:0] i_result_index
);
    logic [4:0] chan_q[$];
    logic [3:0] slot_q[$];
    always @(posedge i_ref_clk)
    begin
        if (i_conv_start)
            chan_q.push_back(i_channel_select);
        if (i_result_write)
            slot_q.push_back(i_result_index);
    end
endmodule // analog_inputs_model
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the software trigger program block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    wire [31:0] rdata;
    wire cs;
    wire [4:0] ch;
    wire [3:0] ri;
    wire rw;
    wire busy;
    wire irq;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    int n;
    logic [7:0] tbl[12];
    logic [31:0] v;
    sw_trigger_program #(.CONV_CYCLES(12'd4)) sw_trigger_program_i (.i_ref_clk(clk),
        .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_conv_start(cs), .o_channel_select(ch), .o_result_index(ri),
        .o_result_write(rw), .o_busy(busy), .o_sw_conversion_done_irq(irq));
    analog_inputs_model analog_inputs_model_i (.i_ref_clk(clk), .i_conv_start(cs),
        .i_channel_select(ch), .i_result_write(rw), .i_result_index(ri));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] e);
        check_count++;
        if (seen !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, e, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(what, rdata, e);
    endtask
    // done flag plus reserved-selector flag for the current table
    function automatic logic [31:0] exp_status(input logic unit_b);
        logic rsv;
        rsv = 1'b0;
        for (int m = 0; m < 12; m++)
            if (tbl[m][7] && tbl[m][4:0] > (unit_b ? 5'h10 : 5'h0e))
                rsv = 1'b1;
        return {30'h0, rsv, 1'b1};
    endfunction
    task automatic conclude();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            conclude();
        end
    end
    initial
    begin
        v = $urandom(32'h1abd);
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int w = 0; w < 3; w++)
            rd_chk("reset word", 8'(4 * w), 32'h0);
        rd_chk("unmapped", 8'h40, 32'h0);
        for (int r = 0; r < 5; r++)
        begin
            for (int w = 0; w < 3; w++)
            begin
                v = (r == 0) ? 32'h0 : $urandom();
                for (int k = 0; k < 4; k++)
                    tbl[4 * w + k] = v[8 * k +: 8] & 8'h9f;
                wr_reg(8'(4 * w), v);
                rd_chk("slot word", 8'(4 * w), v & 32'h9f9f9f9f);
            end
            wr_reg(8'h40, 32'hffffffff);
            wr_reg(8'h18, {31'h0, r[0]});
            wr_reg(8'h0c, {30'h0, r[1], 1'b1});
            // a second start mid-run must not add a run
            if (r != 0)
                wr_reg(8'h0c, {30'h0, r[1], 1'b1});
            n = 0;
            do
            begin
                @(posedge clk);
                #1;
                n++;
            end while (busy !== 1'b0 && n < 400);
            repeat (2) @(posedge clk);
            #1;
            chk("irq", irq, r[0]);
            rd_chk("status", 8'h14, exp_status(r[1]));
            for (int m = 0; m < 12; m++)
                if (tbl[m][7])
                begin
                    chk("channel", analog_inputs_model_i.chan_q.pop_front(), tbl[m][4:0]);
                    chk("slot", analog_inputs_model_i.slot_q.pop_front(), m);
                end
            chk("extra", analog_inputs_model_i.chan_q.size(), 0);
            chk("extra slot", analog_inputs_model_i.slot_q.size(), 0);
            rd_chk("control", 8'h0c, {30'h0, r[1], 1'b0});
            wr_reg(8'h14, 32'h3);
            rd_chk("cleared", 8'h14, 32'h0);
            chk("irq off", irq, 1'b0);
        end
        conclude();
    end
endmodule // testbench
`default_nettype wire
